// file: core/esr_map.svh
/*
  Offsets, field positions and reset values of the extended state
  enable registers. Definitions only; included by the core files.
*/
`ifndef ESR_MAP_SVH
`define ESR_MAP_SVH

// ***************************************************
// Register indices and reset values
// ***************************************************
`define ESR_IDX_USER     32'h0000_0000
`define ESR_IDX_SUPV     32'h0000_0da0
`define ESR_USER_RST     64'h0000_0000_0000_0001
`define ESR_SUPV_RST     64'h0000_0000_0000_0000
`define ESR_USER_RSVD    64'hffff_ffff_ffff_fd00
`define ESR_SUPV_RSVD    64'hffff_ffff_ffff_deff

// ***************************************************
// Field positions
// ***************************************************
`define ESR_CR4_OS_BIT   18
`define ESR_L1_OS_BIT    27
`define ESR_L1_XS_BIT    26
`define ESR_S1_SUPV_BIT  3
`define ESR_S1_CMPCT_BIT 1
`define ESR_WV_LO        5
`define ESR_WV_HI        7
`define ESR_KEY_BIT      9
`define ESR_TRACE_BIT    8
`define ESR_DUTY_BIT     13

// ***************************************************
// Query leaves and save area layout
// ***************************************************
`define ESR_LEAF_BASIC   32'h0000_0001
`define ESR_LEAF_XS      32'h0000_000d
`define ESR_SUB_USER     32'h0000_0000
`define ESR_SUB_SUPV     32'h0000_0001
`define ESR_ALIGN_MASK   64'h0000_0000_0000_003f
`define ESR_HDR_OFS      64'h0000_0000_0000_0200
`define ESR_EXT_OFS      64'h0000_0000_0000_0240

`endif

// file: core/esr_pkg.sv
/*
  Types of the extended state enable register block.
  Assumes esr_map.svh supplies the numeric constants.
*/
package esr_pkg;

   typedef enum logic [3:0] {
      ESR_OP_ENW   = 4'h0,
      ESR_OP_ENR   = 4'h1,
      ESR_OP_MRW   = 4'h2,
      ESR_OP_MRR   = 4'h3,
      ESR_OP_CRW   = 4'h4,
      ESR_OP_CRR   = 4'h5,
      ESR_OP_FQ    = 4'h6,
      ESR_OP_SAVE  = 4'h7,
      ESR_OP_RSTOR = 4'h8,
      ESR_OP_WIDE  = 4'h9,
      ESR_OP_KEY   = 4'ha
   } esr_op_t;

   typedef enum logic [1:0] {
      ESR_FLT_NONE = 2'h0,
      ESR_FLT_UD   = 2'h1,
      ESR_FLT_GP   = 2'h2
   } esr_fault_t;

   typedef struct packed {
      esr_op_t     op;
      logic        supv;
      logic [1:0]  priv;
      logic [31:0] idx;
      logic [31:0] sub;
      logic [63:0] data;
   } esr_req_t;

   typedef struct packed {
      logic        valid;
      esr_fault_t  fault;
      logic [31:0] ra;
      logic [31:0] rb;
      logic [31:0] rc;
      logic [31:0] rd;
   } esr_resp_t;

   typedef struct packed {
      logic        go;
      logic [63:0] legacy;
      logic [63:0] header;
      logic [63:0] ext;
      logic [63:0] mask;
   } esr_area_t;

   typedef struct packed {
      logic [63:0] user;
      logic [63:0] supv;
      logic        os;
      logic        wide_en;
      esr_resp_t   resp;
      esr_area_t   area;
   } esr_state_t;

endpackage : esr_pkg

// file: core/esr_wr_chk.sv
/*
  Combinational legality check of a value written to either
  component enable register. Assumes the support masks are stable
  configuration from the same clock domain.
*/
`timescale 1ns/1ps
`include "esr_map.svh"

module esr_wr_chk
   import esr_pkg::*;
(
   input  wire logic [63:0] val_i,
   input  wire logic [63:0] supp_i,
   input  wire logic        is_supv_i,
   output logic             bad_o
);

   logic bad_user;
   logic bad_supv;
   logic [2:0] wv;

   always_comb
   begin
      wv       = val_i[`ESR_WV_HI:`ESR_WV_LO];
      bad_supv = |(val_i & `ESR_SUPV_RSVD)          // RULE_16
               | |(val_i & ~supp_i);
      bad_user = |(val_i & `ESR_USER_RSVD)          // RULE_08
               | |(val_i & ~supp_i)                 // RULE_03 RULE_07
               | ~val_i[0]                          // RULE_22
               | (val_i[2:1] == 2'h2)
               | (val_i[4] != val_i[3])
               | ((wv != 3'h0)                      // RULE_04
                  & ((wv != 3'h7) | (val_i[2:1] != 2'h3)));
      bad_o    = is_supv_i ? bad_supv : bad_user;
   end

endmodule : esr_wr_chk

// file: core/esr_regs.sv
/*
  Extended state enable register block: the user and supervisor
  component enable registers, the save enable bit of control
  register four, instruction legality and save area layout.
  Assumes the decoder offers at most one request per clock and
  takes the answer one clock later.
*/
// Overview of operation
// [RULE_01] Wide-vector ops run only with save enable and bits 7:5 all set.
// [RULE_02] Bits 7:5 of the user enable register are clear after reset.
// [RULE_03] Bits 7:5 may be set only when the query reports them supported.
// [RULE_04] Writing partial wide-vector bits or lacking bits 2:1 faults.
// [RULE_05] Clearing wide-vector enables keeps the vector state intact.
// [RULE_06] Bit 9 selects key state saving only; key ops always execute.
// [RULE_07] Bit 9 resets clear and is settable only when reported supported.
// [RULE_08] Bit 8 and bits 63:10 are reserved; writing them faults.
// [RULE_09] Reading control register four above privilege 0 faults.
// [RULE_10] Query leaf 1 mirrors save enable into result bit 27.
// [RULE_11] Reading index 0 returns all 64 bits at any privilege.
// [RULE_12] The supervisor register clears on reset.
// [RULE_13] Privileged model write loads the supervisor register when allowed.
// [RULE_14] Supervisor bit 8 selects trace state saving only.
// [RULE_15] Supervisor bit 13 selects duty-cycle state saving only.
// [RULE_16] Supervisor reserved bits reset clear; writing them faults.
// [RULE_17] Unprivileged code has no way to read the supervisor register.
// [RULE_18] Software gives save ops a 64-byte aligned area base.
// [RULE_19] Legacy state takes the first 512 bytes of the area.
// [RULE_20] A 64-byte header starts at byte 512.
// [RULE_21] The extended region starts at byte 576.
// [RULE_22] User enable bit 0 always reads as one.
// [RULE_23] A privileged write to index 0 loads the user register.
// [RULE_24] With save enable clear, save, restore and enable ops fault.
// [RULE_25] A faulting write leaves the register unchanged.
`timescale 1ns/1ps
`include "esr_map.svh"

module esr_regs
   import esr_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        req_valid_i,
   input  wire esr_req_t    req_i,
   input  wire logic [63:0] user_supp_i,
   input  wire logic [63:0] supv_supp_i,
   input  wire logic        xs_supp_i,
   output esr_resp_t        resp_o,
   output esr_area_t        area_o,
   output logic [63:0]      user_en_o,
   output logic [63:0]      supv_en_o,
   output logic             os_enable_o,
   output logic             wide_en_o,
   output logic             key_manage_o,
   output logic             trace_manage_o,
   output logic             duty_manage_o
);

   // ***************************************************
   // State and write check
   // ***************************************************
   esr_state_t q;
   esr_state_t d;
   logic       wr_bad;
   logic       is_supv_wr;
   logic       priv0;

   function automatic logic wide_ok(input logic [63:0] u);
      wide_ok = (u[`ESR_WV_HI:`ESR_WV_LO] == 3'h7);
   endfunction : wide_ok

   assign is_supv_wr = (req_i.op == ESR_OP_MRW);
   assign priv0      = (req_i.priv == 2'h0);

   esr_wr_chk u_chk
   (
      .val_i     (req_i.data),
      .supp_i    (is_supv_wr ? supv_supp_i : user_supp_i),
      .is_supv_i (is_supv_wr),
      .bad_o     (wr_bad)
   );

   // ***************************************************
   // Request decode
   // ***************************************************
   always_comb
   begin
      d         = q;
      d.resp    = '0;
      d.area.go = 1'b0;
      if (req_valid_i)
      begin
         d.resp.valid = 1'b1;
         unique case (req_i.op)
            ESR_OP_ENW:
            begin
               if (!q.os)
                  d.resp.fault = ESR_FLT_UD;           // RULE_24
               else if (!priv0 || req_i.idx != `ESR_IDX_USER)
                  d.resp.fault = ESR_FLT_GP;
               else if (wr_bad)
                  d.resp.fault = ESR_FLT_GP;           // RULE_25
               else
                  d.user = req_i.data;                 // RULE_23
            end
            ESR_OP_ENR:
            begin
               if (!q.os)
                  d.resp.fault = ESR_FLT_UD;           // RULE_24
               else if (req_i.idx != `ESR_IDX_USER)
                  d.resp.fault = ESR_FLT_GP;
               else
               begin
                  d.resp.ra = q.user[31:0];            // RULE_11
                  d.resp.rd = q.user[63:32];
                  d.resp.ra[0] = 1'b1;                 // RULE_22
               end
            end
            ESR_OP_MRW:
            begin
               if (!priv0 || req_i.idx != `ESR_IDX_SUPV)
                  d.resp.fault = ESR_FLT_GP;
               else if (!q.os || !xs_supp_i || wr_bad)
                  d.resp.fault = ESR_FLT_GP;           // RULE_16
               else
                  d.supv = req_i.data;                 // RULE_13
            end
            ESR_OP_MRR:
            begin
               if (!priv0)
                  d.resp.fault = ESR_FLT_GP;           // RULE_17
               else if (req_i.idx != `ESR_IDX_SUPV || !xs_supp_i)
                  d.resp.fault = ESR_FLT_GP;
               else
               begin
                  d.resp.ra = q.supv[31:0];
                  d.resp.rd = q.supv[63:32];
               end
            end
            ESR_OP_CRW:
            begin
               if (!priv0)
                  d.resp.fault = ESR_FLT_GP;
               else
                  d.os = req_i.data[`ESR_CR4_OS_BIT];
            end
            ESR_OP_CRR:
            begin
               if (!priv0)
                  d.resp.fault = ESR_FLT_GP;           // RULE_09
               else
                  d.resp.ra[`ESR_CR4_OS_BIT] = q.os;
            end
            ESR_OP_FQ:
            begin
               // Every privilege level may query
               if (req_i.idx == `ESR_LEAF_BASIC)
               begin
                  d.resp.rc[`ESR_L1_OS_BIT] = q.os;    // RULE_10
                  d.resp.rc[`ESR_L1_XS_BIT] = 1'b1;
               end
               else if (req_i.idx == `ESR_LEAF_XS &&
                        req_i.sub == `ESR_SUB_USER)
               begin
                  d.resp.ra = user_supp_i[31:0];
                  d.resp.rd = user_supp_i[63:32];
               end
               else if (req_i.idx == `ESR_LEAF_XS &&
                        req_i.sub == `ESR_SUB_SUPV)
               begin
                  d.resp.ra[`ESR_S1_SUPV_BIT]  = xs_supp_i;
                  d.resp.ra[`ESR_S1_CMPCT_BIT] = xs_supp_i;
                  d.resp.rc = supv_supp_i[31:0];
                  d.resp.rd = supv_supp_i[63:32];
               end
            end
            ESR_OP_SAVE,
            ESR_OP_RSTOR:
            begin
               if (!q.os || (req_i.supv && !xs_supp_i))
                  d.resp.fault = ESR_FLT_UD;           // RULE_24
               else if (req_i.supv && !priv0)
                  d.resp.fault = ESR_FLT_GP;
               else if (|(req_i.data & `ESR_ALIGN_MASK))
                  d.resp.fault = ESR_FLT_GP;           // RULE_18
               else
               begin
                  d.area.go     = 1'b1;
                  d.area.legacy = req_i.data;          // RULE_19
                  d.area.header = req_i.data + `ESR_HDR_OFS; // RULE_20
                  d.area.ext    = req_i.data + `ESR_EXT_OFS; // RULE_21
                  // Trace and duty state only ride along in
                  // the supervisor form
                  d.area.mask   = q.user |                   // RULE_14
                     (req_i.supv ? q.supv : '0);             // RULE_15
               end
            end
            ESR_OP_WIDE:
            begin
               if (!q.os || !wide_ok(q.user))
                  d.resp.fault = ESR_FLT_UD;           // RULE_01
            end
            ESR_OP_KEY:
            begin
               // Key instructions never depend on bit 9
               d.resp.fault = ESR_FLT_NONE;            // RULE_06
            end
            default:
            begin
               d.resp.fault = ESR_FLT_UD;
            end
         endcase
      end
      // Enables only gate use; the vector register file itself is
      // never cleared here, so its contents survive a disable.
      d.wide_en = d.os & wide_ok(d.user);              // RULE_05
   end

   // ***************************************************
   // State register
   // ***************************************************
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         q      <= '0;
         q.user <= `ESR_USER_RST;                      // RULE_02 RULE_07
         q.supv <= `ESR_SUPV_RST;                      // RULE_12
      end
      else
      begin
         q <= d;
      end
   end

   // ***************************************************
   // Outputs
   // ***************************************************
   assign resp_o         = q.resp;
   assign area_o         = q.area;
   assign user_en_o      = q.user;
   assign supv_en_o      = q.supv;
   assign os_enable_o    = q.os;
   assign wide_en_o      = q.wide_en;
   assign key_manage_o   = q.user[`ESR_KEY_BIT];
   assign trace_manage_o = q.supv[`ESR_TRACE_BIT];
   assign duty_manage_o  = q.supv[`ESR_DUTY_BIT];

   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   sequence s_req(esr_op_t op);
      req_valid_i && req_i.op == op;
   endsequence

   sequence s_enw_bad;
      s_req(ESR_OP_ENW) ##0 (q.os && priv0 && wr_bad);
   endsequence

   sequence s_mrw_bad;
      s_req(ESR_OP_MRW) ##0 (!priv0 || wr_bad);
   endsequence

   chk_reset_user: assert property (disable iff (1'b0)  // RULE_02
      !reset_n_i |=> (q.user == `ESR_USER_RST && q.supv == '0))
      else $error("enable registers not cleared by reset");

   chk_enw_bad_keeps: assert property (               // RULE_25
      s_enw_bad |=> (resp_o.fault == ESR_FLT_GP) && $stable(q.user))
      else $error("faulting write changed user register");

   chk_mrw_bad_keeps: assert property (               // RULE_16
      s_mrw_bad |=> (resp_o.fault == ESR_FLT_GP) && $stable(q.supv))
      else $error("faulting model write changed register");

   chk_wide_pairs: assert property (                  // RULE_04
      q.user[7:5] == 3'h0 ||
      (q.user[7:5] == 3'h7 && q.user[2:1] == 2'h3))
      else $error("wide vector enables partly set");

   chk_bit0_set: assert property (                    // RULE_22
      q.user[0] && !(|(q.user & `ESR_USER_RSVD)))
      else $error("user enable bit 0 clear or reserved set");

   chk_wide_ud: assert property (                     // RULE_01
      s_req(ESR_OP_WIDE) |=>
      (resp_o.fault == ESR_FLT_UD) == !$past(wide_en_o))
      else $error("wide vector fault mismatch");

   chk_cr_priv: assert property (                     // RULE_09
      s_req(ESR_OP_CRR) ##0 !priv0 |=> resp_o.fault == ESR_FLT_GP)
      else $error("unprivileged control read not refused");

   chk_supv_hidden: assert property (                 // RULE_17
      s_req(ESR_OP_MRR) ##0 !priv0 |=>
      resp_o.fault == ESR_FLT_GP && resp_o.ra == '0 && resp_o.rd == '0)
      else $error("supervisor register leaked");

   chk_query_os: assert property (                    // RULE_10
      s_req(ESR_OP_FQ) ##0 req_i.idx == `ESR_LEAF_BASIC |=>
      resp_o.rc[`ESR_L1_OS_BIT] == $past(q.os))
      else $error("query does not mirror save enable");

   chk_area_ofs: assert property (                    // RULE_21
      area_o.go |->
      area_o.header - area_o.legacy == `ESR_HDR_OFS &&
      area_o.ext - area_o.legacy == `ESR_EXT_OFS)
      else $error("save area layout wrong");

   chk_os_gate: assert property (                     // RULE_24
      s_req(ESR_OP_ENR) ##0 !q.os |=> resp_o.fault == ESR_FLT_UD &&
      resp_o.ra == '0 && resp_o.rd == '0)
      else $error("enable read ran with save disabled");

endmodule : esr_regs

// file: verif/testbench.sv
/*
  Self-checking bench for esr_regs: directed corner cases and seeded
  random requests, judged against a reference model kept here.
  Assumes each answer shows just after the edge taking the request.
*/
`timescale 1ns/1ps
`include "esr_map.svh"

module testbench
   import esr_pkg::*;
;
   logic        clk_i;
   logic        reset_n_i;
   logic        req_valid_i;
   esr_req_t    req_i;
   logic [63:0] user_supp_i;
   logic [63:0] supv_supp_i;
   logic        xs_supp_i;
   esr_resp_t   resp_o;
   esr_area_t   area_o;
   logic [63:0] user_en_o;
   logic [63:0] supv_en_o;
   logic        os_enable_o;
   logic        wide_en_o;
   logic        key_manage_o;
   logic        trace_manage_o;
   logic        duty_manage_o;
   logic [63:0] m_user;
   logic [63:0] m_supv;
   logic        m_os;
   int          n_errors = 0;
   int          compares = 0;
   int          cycles   = 0;
   integer      seed;
   logic [63:0] vals [8] = '{64'h3, 64'he7, 64'h2e7, 64'h87, 64'he3,
                             64'h100, 64'h2100, 64'h0000_0100_0000_0003};

   esr_regs i_esr_regs (
      .clk_i          (clk_i),
      .reset_n_i      (reset_n_i),
      .req_valid_i    (req_valid_i),
      .req_i          (req_i),
      .user_supp_i    (user_supp_i),
      .supv_supp_i    (supv_supp_i),
      .xs_supp_i      (xs_supp_i),
      .resp_o         (resp_o),
      .area_o         (area_o),
      .user_en_o      (user_en_o),
      .supv_en_o      (supv_en_o),
      .os_enable_o    (os_enable_o),
      .wide_en_o      (wide_en_o),
      .key_manage_o   (key_manage_o),
      .trace_manage_o (trace_manage_o),
      .duty_manage_o  (duty_manage_o)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // A hung handshake must still reach the verdict
   always @(posedge clk_i)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         n_errors = n_errors + 1;
         wrap_up();
      end
   end

   // ***************************************************
   // Reporting
   // ***************************************************
   task automatic wrap_up();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
      compares = compares + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_val

   task automatic chk_flt(input esr_fault_t got, input esr_fault_t exp);
      compares = compares + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_flt

   // ***************************************************
   // Reference model
   // ***************************************************
   function automatic logic bad_user(input logic [63:0] v);
      return (v & `ESR_USER_RSVD) != 0 || (v & ~user_supp_i) != 0 ||
             !v[0] || v[2:1] == 2'b10 || v[4] != v[3] ||
             (v[7:5] != 0 && !(v[7:5] == 3'b111 && v[2:1] == 2'b11));
   endfunction : bad_user

   function automatic esr_fault_t exp_fault(input esr_req_t r);
      case (r.op)
         ESR_OP_ENW:
            if (!m_os) return ESR_FLT_UD;
            else if (r.priv != 0 || r.idx != `ESR_IDX_USER ||
                     bad_user(r.data)) return ESR_FLT_GP;
         ESR_OP_ENR:
            if (!m_os) return ESR_FLT_UD;
            else if (r.idx != `ESR_IDX_USER) return ESR_FLT_GP;
         ESR_OP_MRW:
            if (r.priv != 0 || r.idx != `ESR_IDX_SUPV || !m_os ||
                !xs_supp_i || (r.data & `ESR_SUPV_RSVD) != 0 ||
                (r.data & ~supv_supp_i) != 0) return ESR_FLT_GP;
         ESR_OP_MRR:
            if (r.priv != 0 || r.idx != `ESR_IDX_SUPV || !xs_supp_i)
               return ESR_FLT_GP;
         ESR_OP_CRW, ESR_OP_CRR:
            if (r.priv != 0) return ESR_FLT_GP;
         ESR_OP_SAVE, ESR_OP_RSTOR:
            if (!m_os || (r.supv && !xs_supp_i)) return ESR_FLT_UD;
            else if ((r.supv && r.priv != 0) || r.data[5:0] != 0)
               return ESR_FLT_GP;
         ESR_OP_WIDE:
            if (!(m_os && m_user[7:5] == 3'b111)) return ESR_FLT_UD;
         ESR_OP_FQ, ESR_OP_KEY: ;
         default: return ESR_FLT_UD;
      endcase
      return ESR_FLT_NONE;
   endfunction : exp_fault

   // ***************************************************
   // Drivers
   // ***************************************************
   task automatic chk_regs();
      chk_val(user_en_o, m_user);
      chk_val(supv_en_o, m_supv);
      chk_val({59'h0, os_enable_o, wide_en_o, key_manage_o,
               trace_manage_o, duty_manage_o},
              {59'h0, m_os, m_os && m_user[7:5] == 3'b111, m_user[9],
               m_supv[8], m_supv[13]});
   endtask : chk_regs

   // Leaves valid high so back-to-back requests need no gap
   task automatic send(input esr_op_t op, input logic [1:0] priv,
                       input logic [31:0] idx, input logic [63:0] data,
                       input logic supv);
      esr_fault_t f;
      logic [63:0] msk;
      req_i       = '{op: op, supv: supv, priv: priv, idx: idx,
                      sub: 32'h0, data: data};
      req_valid_i = 1'b1;
      f           = exp_fault(req_i);
      msk         = m_user | (supv ? m_supv : 64'h0);
      @(posedge clk_i);
      #1;
      chk_val(64'(resp_o.valid), 64'h1);
      chk_flt(resp_o.fault, f);
      chk_val(64'(area_o.go), 64'((op == ESR_OP_SAVE || op == ESR_OP_RSTOR)
                                  && f == ESR_FLT_NONE));
      if (f == ESR_FLT_NONE)
      begin
         case (op)
            ESR_OP_ENR: chk_val({resp_o.rd, resp_o.ra}, m_user | 64'h1);
            ESR_OP_MRR: chk_val({resp_o.rd, resp_o.ra}, m_supv);
            ESR_OP_CRR: chk_val({resp_o.rd, resp_o.ra}, {45'h0, m_os, 18'h0});
            ESR_OP_FQ:
               if (idx == `ESR_LEAF_BASIC)
                  chk_val(64'(resp_o.rc[27]), 64'(m_os));
               else if (idx == `ESR_LEAF_XS)
                  chk_val({resp_o.rd, resp_o.ra}, user_supp_i);
            ESR_OP_SAVE, ESR_OP_RSTOR:
            begin
               chk_val(area_o.legacy, data);
               chk_val(area_o.header, data + 64'h200);
               chk_val(area_o.ext, data + 64'h240);
               chk_val(area_o.mask, msk);
            end
            ESR_OP_ENW: m_user = data;
            ESR_OP_MRW: m_supv = data;
            ESR_OP_CRW: m_os = data[18];
            default: ;
         endcase
      end
      chk_regs();
   endtask : send

   task automatic idle();
      req_valid_i = 1'b0;
      @(posedge clk_i);
      #1;
      chk_val({61'h0, resp_o.valid, resp_o.fault}, 64'h0);
   endtask : idle

   task automatic do_reset();
      @(posedge clk_i);
      #1;
      reset_n_i   = 1'b0;
      req_valid_i = 1'b0;
      repeat (10) @(posedge clk_i);
      #1;
      reset_n_i = 1'b1;
      m_user    = `ESR_USER_RST;
      m_supv    = `ESR_SUPV_RST;
      m_os      = 1'b0;
      chk_regs();
   endtask : do_reset

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial
   begin : main
      logic [31:0] r;
      seed        = 32'h0d62;
      reset_n_i   = 1'b0;
      req_valid_i = 1'b0;
      req_i       = '0;
      user_supp_i = 64'h2ff;
      supv_supp_i = 64'h2100;
      xs_supp_i   = 1'b1;
      do_reset();
      send(ESR_OP_ENW, 2'h0, 32'h0, 64'he7, 1'b0);
      send(ESR_OP_ENR, 2'h0, 32'h0, 64'h0, 1'b0);
      send(ESR_OP_SAVE, 2'h0, 32'h0, 64'h1000, 1'b0);
      send(ESR_OP_WIDE, 2'h0, 32'h0, 64'h0, 1'b0);
      send(ESR_OP_CRR, 2'h3, 32'h0, 64'h0, 1'b0);
      send(ESR_OP_CRW, 2'h0, 32'h0, 64'h4_0000, 1'b0);
      send(ESR_OP_FQ, 2'h3, `ESR_LEAF_BASIC, 64'h0, 1'b0);
      send(ESR_OP_FQ, 2'h3, `ESR_LEAF_XS, 64'h0, 1'b0);
      send(ESR_OP_CRR, 2'h0, 32'h0, 64'h0, 1'b0);
      foreach (vals[i]) send(ESR_OP_ENW, 2'h0, 32'h0, vals[i], 1'b0);
      send(ESR_OP_ENR, 2'h3, 32'h0, 64'h0, 1'b0);
      send(ESR_OP_WIDE, 2'h3, 32'h0, 64'h0, 1'b0);
      send(ESR_OP_ENW, 2'h1, 32'h0, 64'h3, 1'b0);
      send(ESR_OP_ENW, 2'h0, 32'h0, 64'h3, 1'b0);
      send(ESR_OP_WIDE, 2'h0, 32'h0, 64'h0, 1'b0);
      send(ESR_OP_KEY, 2'h3, 32'h0, 64'h0, 1'b0);
      user_supp_i = 64'h21f;
      send(ESR_OP_ENW, 2'h0, 32'h0, 64'he7, 1'b0);
      user_supp_i = 64'hff;
      send(ESR_OP_ENW, 2'h0, 32'h0, 64'h203, 1'b0);
      user_supp_i = 64'h2ff;
      foreach (vals[i]) send(ESR_OP_MRW, 2'h0, `ESR_IDX_SUPV, vals[i], 1'b0);
      send(ESR_OP_MRR, 2'h3, `ESR_IDX_SUPV, 64'h0, 1'b0);
      send(ESR_OP_MRR, 2'h0, `ESR_IDX_SUPV, 64'h0, 1'b0);
      send(ESR_OP_MRW, 2'h3, `ESR_IDX_SUPV, 64'h0, 1'b0);
      xs_supp_i = 1'b0;
      send(ESR_OP_MRW, 2'h0, `ESR_IDX_SUPV, 64'h0, 1'b0);
      send(ESR_OP_SAVE, 2'h0, 32'h0, 64'h1000, 1'b1);
      xs_supp_i = 1'b1;
      send(ESR_OP_SAVE, 2'h0, 32'h0, 64'h1040, 1'b1);
      send(ESR_OP_SAVE, 2'h0, 32'h0, 64'h1010, 1'b0);
      send(ESR_OP_RSTOR, 2'h3, 32'h0, 64'h2000, 1'b0);
      send(esr_op_t'(4'hf), 2'h0, 32'h0, 64'h0, 1'b0);
      repeat (600)
      begin
         r           = $random(seed);
         xs_supp_i   = r[17:16] != 2'h0;
         user_supp_i = (r[19:18] == 2'h0) ? 64'h21f : 64'h2ff;
         send(esr_op_t'(r[3:0] % 4'hc),
              (r[5:4] == 2'h0) ? r[7:6] : 2'h0,
              (r[9:8] == 2'h0) ? 32'(r[31:20]) :
              (r[3:0] % 4'hc == 4'h6) ? `ESR_LEAF_BASIC :
              (r[3:0] % 4'hc inside {4'h2, 4'h3}) ? `ESR_IDX_SUPV : 32'h0,
              r[10] ? vals[r[13:11]] :
              {$random(seed), $random(seed) & (r[14] ? 32'hffff_ffc0 :
                                                      32'hffff_ffff)},
              r[15]);
      end
      idle();
      do_reset();
      send(ESR_OP_ENR, 2'h0, 32'h0, 64'h0, 1'b0);
      idle();
      wrap_up();
   end : main

endmodule : testbench
